// *** dv/bfdrx_peer.sv ***
// Remote peer model: puts one received PDU on the receive lines per request
`timescale 1ns/10ps
module bfdrx_peer (
  input  wire logic                  i_clock,
  input  wire logic                  i_send,
  input  wire bfdrx_pkg::bfdrx_pdu_t i_pdu,
  output logic                       o_valid = 1'b0,
  output bfdrx_pkg::bfdrx_pdu_t      o_pdu = '0
);
  // Idle fields flip every cycle so a stale field never passes for a frame
  always @(posedge i_clock) begin
    o_valid <= i_send;
    o_pdu   <= i_send ? i_pdu : ~o_pdu;
  end
endmodule

// *** dv/tb_bfdrx_top.sv ***
// Testbench: receive checks, sticky flags, sampling, counting and loss
`timescale 1ns/10ps
module tb_bfdrx_top;
  logic I_CLOCK = 1'b0, I_RESETN = 1'b0, I_CLK_EN = 1'b1, I_TX_PDU_VALID = 1'b0, I_TX_IS_CC = 1'b1;
  logic I_TX_FROM_SINK = 1'b0, I_TX_INSERT_EN = 1'b1, I_CONTINUITY_PDU_PROCESS_EN = 1'b1;
  logic I_VERIFY_PDU_PROCESS_EN = 1'b1, I_CC_CHANNEL_TYPE_SELECT = 1'b1, I_CONTINUITY_COUNTER_SELECT = 1'b1;
  logic I_VERIFY_COUNTER_SELECT = 1'b0, I_SINGLE_SESSION_MODE_EN = 1'b1, I_RX_FIELD_SAMPLING_EN = 1'b1;
  logic I_VALIDATE_CC_EN = 1'b1, I_VALIDATE_CV_EN = 1'b1, I_VERSION_CHECK_EN = 1'b1, I_MIN_LEN_CHECK_EN = 1'b1;
  logic I_DISCR_CHECK_EN = 1'b1, I_FLAG_CHECK_EN = 1'b1, I_RX_FAIL_CPU_COPY_EN = 1'b1, I_LOSS_TICK = 1'b0;
  logic I_PDU_VALID, send_req = 1'b0, O_PDU_ACCEPT, O_PDU_DISCARD, O_PDU_TO_SINK, O_CPU_COPY;
  logic O_TX_VALID, O_TX_INSERT, O_CONTINUITY_LOSS;
  logic [2:0]  I_EXPECTED_PROTOCOL_VERSION = 3'h1, why;
  logic [15:0] I_PDU_CHANNEL = 16'h0022, O_RX_SEL_COUNT, O_RX_NONSEL_COUNT, O_TX_SEL_COUNT, O_TX_NONSEL_COUNT;
  logic [31:0] I_SOURCE_LOCAL_DISCRIMINATOR = 32'h0000000A, I_SOURCE_REMOTE_DISCRIMINATOR = 32'h0000000B;
  logic [31:0] I_SINK_LOCAL_DISCRIMINATOR = 32'h0000000D, I_SINK_REMOTE_DISCRIMINATOR = 32'h0000000E;
  logic [1:0]  I_SOURCE_OWN_STATE = 2'h1, I_SINK_OWN_STATE = 2'h2, I_PDU_STATE = 2'h2;
  logic [1:0]  O_SOURCE_PEER_STATE, O_SINK_PEER_STATE, O_TX_STATE;
  logic [4:0]  I_SOURCE_OWN_DIAG = 5'h03, I_SINK_OWN_DIAG = 5'h07, I_PDU_DIAG = 5'h05;
  logic [4:0]  O_SOURCE_PEER_DIAG, O_SINK_PEER_DIAG, O_TX_DIAG;
  logic [7:0]  I_MAX_PDU_LENGTH = 8'h30, I_SOURCE_OWN_MULTIPLIER = 8'h04, I_SINK_OWN_MULTIPLIER = 8'h06;
  logic [7:0]  O_SOURCE_PEER_MULTIPLIER, O_SINK_PEER_MULTIPLIER, O_TX_MULTIPLIER, O_LOSS_COUNT;
  logic [6:0]  I_STICKY_CLEAR = 7'h00, O_STICKY, exp_stk = 7'h00;
  int          failures = 0, check_count = 0;
  bfdrx_pkg::bfdrx_pdu_t peer_pdu, pdu_in = '0;
  wire logic [2:0]  I_PDU_VERSION = peer_pdu.version;
  wire logic [7:0]  I_PDU_LENGTH = peer_pdu.length, I_PDU_MULT = peer_pdu.mult;
  wire logic        I_PDU_AUTH = peer_pdu.auth, I_PDU_MULTIPOINT = peer_pdu.multipoint;
  wire logic [31:0] I_PDU_MY_DISC = peer_pdu.my_disc, I_PDU_YOUR_DISC = peer_pdu.your_disc;
  // Version, length, auth and multipoint, multiplier, my and your discriminator, failure code
  logic [39:0] rows [10] = '{
    {3'h1,8'h18,2'h0,8'h03,8'h0B,8'h0A,3'h0}, {3'h2,8'h17,2'h3,8'h00,8'h00,8'h00,3'h1},
    {3'h1,8'h17,2'h0,8'h00,8'h0B,8'h0A,3'h2}, {3'h1,8'h19,2'h2,8'h03,8'h0B,8'h0A,3'h2},
    {3'h1,8'h31,2'h1,8'h03,8'h0B,8'h0A,3'h3}, {3'h1,8'h30,2'h0,8'h03,8'h0B,8'h0A,3'h0},
    {3'h1,8'h18,2'h1,8'h00,8'h0B,8'h0A,3'h4}, {3'h1,8'h18,2'h1,8'h03,8'h0B,8'h0A,3'h5},
    {3'h1,8'h18,2'h0,8'h03,8'h0A,8'h0B,3'h6}, {3'h1,8'h18,2'h0,8'h03,8'h0C,8'h0A,3'h7}};
  bfdrx_top i_bfdrx_top (.*);
  bfdrx_peer i_bfdrx_peer (.i_clock(I_CLOCK), .i_send(send_req), .i_pdu(pdu_in), .o_valid(I_PDU_VALID), .o_pdu(peer_pdu));
  always #12.5 I_CLOCK = ~I_CLOCK;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Peer registers the request, so the verdict shows two edges after it
  task automatic send(input logic [39:0] r);
    @(posedge I_CLOCK);
    send_req <= 1'b1;
    pdu_in   <= {r[39:37], r[36:29], r[28:27], r[26:19], 24'h000000, r[18:11], 24'h000000, r[10:3]};
    @(posedge I_CLOCK);
    send_req <= 1'b0;
    @(posedge I_CLOCK);
    #1;
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge I_CLOCK);
    I_RESETN <= 1'b1;
    #1;
    chk(32'({O_STICKY, O_PDU_ACCEPT, O_LOSS_COUNT}), 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      send(rows[i]);
      why = rows[i][2:0];
      if (why != 3'h0) exp_stk[why - 3'h1] = 1'b1;
      chk(32'({O_PDU_ACCEPT, O_PDU_DISCARD, O_CPU_COPY}), 32'({why == 3'h0, {2{why != 3'h0}}}));
      chk(32'(O_STICKY), 32'(exp_stk));
    end
    chk(32'({O_SOURCE_PEER_STATE, O_SOURCE_PEER_DIAG, O_SOURCE_PEER_MULTIPLIER}), 32'h00004503);
    chk(32'(O_RX_SEL_COUNT), 32'h2);
    $display("row tests done");
    repeat (3) begin
      @(posedge I_CLOCK);
      I_LOSS_TICK <= 1'b1;
    end
    @(posedge I_CLOCK);
    I_LOSS_TICK <= 1'b0;
    #1;
    chk(32'({O_LOSS_COUNT, O_CONTINUITY_LOSS}), 32'h7);
    $display("loss test done");
    @(posedge I_CLOCK);
    I_STICKY_CLEAR <= 7'h7F;
    I_CONTINUITY_PDU_PROCESS_EN <= 1'b0;
    send(rows[1]);
    chk(32'({O_PDU_ACCEPT, O_PDU_DISCARD, O_STICKY}), 32'h0);
    $display("disable test done");
    @(posedge I_CLOCK);
    I_TX_PDU_VALID <= 1'b1;
    I_TX_FROM_SINK <= 1'b1;
    @(posedge I_CLOCK);
    I_TX_PDU_VALID <= 1'b0;
    I_SINGLE_SESSION_MODE_EN <= 1'b0;
    I_CONTINUITY_PDU_PROCESS_EN <= 1'b1;
    #1;
    chk(32'({O_TX_INSERT, O_TX_STATE, O_TX_DIAG, O_TX_MULTIPLIER, O_TX_SEL_COUNT}), 32'hA3040001);
    send({3'h1, 8'h18, 2'h0, 8'h05, 8'h0E, 8'h0D, 3'h0});
    chk(32'({O_PDU_ACCEPT, O_PDU_TO_SINK, O_SINK_PEER_MULTIPLIER, O_LOSS_COUNT}), 32'h30500);
    @(posedge I_CLOCK);
    I_DISCR_CHECK_EN <= 1'b0;
    I_CC_CHANNEL_TYPE_SELECT <= 1'b0;
    I_PDU_CHANNEL <= 16'h0007;
    send({3'h1, 8'h18, 2'h0, 8'h05, 8'h0E, 8'h0D, 3'h0});
    chk(32'({O_PDU_ACCEPT, O_PDU_TO_SINK, O_SOURCE_PEER_MULTIPLIER}), 32'h205);
    $display("mode test done");
    print_verdict;
  end
endmodule

// *** rtl/bfdrx_checker.sv ***
// Ordered receive checks and session selection, purely combinational
`timescale 1ns/10ps
module bfdrx_checker (
  bfdrx_chk_if.decider chk
);

  // ****************************************
  // Individual checks
  // ****************************************
  wire en         = chk.cfg.validate_en;
  wire bad_ver    = en && chk.cfg.version_check_en && (chk.pdu.version != chk.cfg.expected_version); // R13
  wire bad_short  = en && chk.cfg.min_len_check_en &&
                    (chk.pdu.length < (chk.pdu.auth ? bfdrx_pkg::MIN_LEN_AUTH : bfdrx_pkg::MIN_LEN_PLAIN)); // R14
  wire bad_long   = en && (chk.pdu.length > chk.cfg.max_len); // R15
  wire bad_mult   = en && chk.cfg.flag_check_en && (chk.pdu.mult == bfdrx_pkg::MULT_RST); // R16
  wire bad_mpt    = en && chk.cfg.flag_check_en && chk.pdu.multipoint; // R17
  wire disc_on    = en && chk.cfg.discr_check_en;
  wire hit_src    = (chk.pdu.your_disc == chk.cfg.src_local_disc); // R19
  wire hit_sink   = !chk.cfg.single_session && (chk.pdu.your_disc == chk.cfg.sink_local_disc); // R20
  // Source wins if both locals match; software should keep them distinct
  wire far_end    = disc_on && !hit_src && hit_sink; // R20 R22
  wire bad_your   = disc_on && !hit_src && !hit_sink; // R19 R20
  wire [bfdrx_pkg::DISC_W-1:0] exp_my = far_end ? chk.cfg.sink_remote_disc : chk.cfg.src_remote_disc;
  wire bad_my     = disc_on && (chk.pdu.my_disc != exp_my); // R21

  // ****************************************
  // First failing check wins
  // ****************************************
  assign chk.fail = bad_ver   ? bfdrx_pkg::BFDRX_FAIL_VERSION    :
                    bad_short ? bfdrx_pkg::BFDRX_FAIL_SHORT_LEN  :
                    bad_long  ? bfdrx_pkg::BFDRX_FAIL_LONG_LEN   :
                    bad_mult  ? bfdrx_pkg::BFDRX_FAIL_ZERO_MULT  :
                    bad_mpt   ? bfdrx_pkg::BFDRX_FAIL_MULTIPOINT :
                    bad_your  ? bfdrx_pkg::BFDRX_FAIL_YOUR_DISC  :
                    bad_my    ? bfdrx_pkg::BFDRX_FAIL_MY_DISC    :
                                bfdrx_pkg::BFDRX_PASS; // R12
  assign chk.to_sink = far_end;

endmodule

// *** rtl/bfdrx_chk_if.sv ***
// Interface: PDU fields and configuration to the checker, verdict back
`timescale 1ns/10ps
interface bfdrx_chk_if;
  bfdrx_pkg::bfdrx_pdu_t  pdu;
  bfdrx_pkg::bfdrx_cfg_t  cfg;
  bfdrx_pkg::bfdrx_fail_t fail;
  logic                   to_sink;

  modport requester (output pdu, output cfg, input fail, input to_sink);
  modport decider   (input pdu, input cfg, output fail, output to_sink);
endinterface

// *** rtl/bfdrx_pkg.sv ***
// Package: widths, codes, checks and reset values for the BFD receive validation block
package bfdrx_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int DISC_W  = 32;
  localparam int LEN_W   = 8;
  localparam int MULT_W  = 8;
  localparam int STATE_W = 2;
  localparam int DIAG_W  = 5;
  localparam int VER_W   = 3;
  localparam int CHAN_W  = 16;
  localparam int CNT_W   = 16;
  localparam int FAIL_N  = 7;

  // ****************************************
  // Channel types and length limits
  // ****************************************
  localparam logic [CHAN_W-1:0] CHAN_CC_ALT = 16'h0007;
  localparam logic [CHAN_W-1:0] CHAN_CC_STD = 16'h0022;
  localparam logic [CHAN_W-1:0] CHAN_CV     = 16'h0023;
  // 24 and 26 bytes
  localparam logic [LEN_W-1:0]  MIN_LEN_PLAIN = 8'h18;
  localparam logic [LEN_W-1:0]  MIN_LEN_AUTH  = 8'h1A;

  // ****************************************
  // Sticky bit positions
  // ****************************************
  localparam int STK_VERSION    = 0;
  localparam int STK_SHORT_LEN  = 1;
  localparam int STK_LONG_LEN   = 2;
  localparam int STK_ZERO_MULT  = 3;
  localparam int STK_MULTIPOINT = 4;
  localparam int STK_YOUR_DISC  = 5;
  localparam int STK_MY_DISC    = 6;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [FAIL_N-1:0]  STICKY_RST = 7'h00;
  localparam logic [CNT_W-1:0]   CNT_RST    = 16'h0000;
  localparam logic [MULT_W-1:0]  MULT_RST   = 8'h00;
  localparam logic [STATE_W-1:0] STATE_RST  = 2'h0;
  localparam logic [DIAG_W-1:0]  DIAG_RST   = 5'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    BFDRX_PASS,
    BFDRX_FAIL_VERSION,
    BFDRX_FAIL_SHORT_LEN,
    BFDRX_FAIL_LONG_LEN,
    BFDRX_FAIL_ZERO_MULT,
    BFDRX_FAIL_MULTIPOINT,
    BFDRX_FAIL_YOUR_DISC,
    BFDRX_FAIL_MY_DISC
  } bfdrx_fail_t;

  typedef struct packed {
    logic [VER_W-1:0]  version;
    logic [LEN_W-1:0]  length;
    logic              auth;
    logic              multipoint;
    logic [MULT_W-1:0] mult;
    logic [DISC_W-1:0] my_disc;
    logic [DISC_W-1:0] your_disc;
  } bfdrx_pdu_t;

  typedef struct packed {
    logic              validate_en;
    logic              version_check_en;
    logic              min_len_check_en;
    logic              discr_check_en;
    logic              flag_check_en;
    logic              single_session;
    logic [VER_W-1:0]  expected_version;
    logic [LEN_W-1:0]  max_len;
    logic [DISC_W-1:0] src_local_disc;
    logic [DISC_W-1:0] src_remote_disc;
    logic [DISC_W-1:0] sink_local_disc;
    logic [DISC_W-1:0] sink_remote_disc;
  } bfdrx_cfg_t;

endpackage

// *** rtl/bfdrx_top.sv ***
// BFD session receive validation, sampling, counting and loss detection
// Function
// R1: Handle CC PDUs only when CC enabled, CV PDUs only when CV enabled.
// R2: CC channel type is chosen by a configuration bit.
// R3: Tx and Rx CC/CV PDUs go to selected or non-selected counters.
// R4: Mode bit high: one coordinated session using only source function values.
// R5: Mode bit low: independent mode using both source and sink functions.
// R6: Source discriminators and own fields come from software, never changed here.
// R7: Sink discriminators and own fields come from software, never changed here.
// R8: Own state, diag and multiplier optionally inserted into transmitted frames.
// R9: Sampling on: copy state, diag, multiplier of valid CC PDU to session.
// R10: Loss event when loss count reaches the relevant peer multiplier.
// R11: Failing PDUs are discarded and set a reason sticky bit.
// R12: Checks run in fixed order; first failure is the only reason.
// R13: Version must equal the programmed 3-bit version.
// R14: Length below 24, or 26 with authentication, is rejected.
// R15: Length above configured maximum is rejected.
// R16: Zero detect multiplier is rejected.
// R17: Multipoint flag set is rejected.
// R18: Failing PDUs optionally copied to the CPU under one enable.
// R19: Coordinated: your-discriminator must match source local discriminator.
// R20: Independent: your-discriminator picks near or far session, else rejected.
// R21: My-discriminator must match the chosen session's remote discriminator.
// R22: Discriminator checks off: PDU belongs to coordinated or near-end session.
// R23: Sticky bits hold until software clears them.
`timescale 1ns/10ps
module bfdrx_top (
  input  wire logic                             I_CLOCK,
  input  wire logic                             I_RESETN,
  input  wire logic                             I_CLK_EN,
  // Received PDU
  input  wire logic                             I_PDU_VALID,
  input  wire logic [bfdrx_pkg::CHAN_W-1:0]     I_PDU_CHANNEL,
  input  wire logic [bfdrx_pkg::VER_W-1:0]      I_PDU_VERSION,
  input  wire logic [bfdrx_pkg::LEN_W-1:0]      I_PDU_LENGTH,
  input  wire logic                             I_PDU_AUTH,
  input  wire logic                             I_PDU_MULTIPOINT,
  input  wire logic [bfdrx_pkg::STATE_W-1:0]    I_PDU_STATE,
  input  wire logic [bfdrx_pkg::DIAG_W-1:0]     I_PDU_DIAG,
  input  wire logic [bfdrx_pkg::MULT_W-1:0]     I_PDU_MULT,
  input  wire logic [bfdrx_pkg::DISC_W-1:0]     I_PDU_MY_DISC,
  input  wire logic [bfdrx_pkg::DISC_W-1:0]     I_PDU_YOUR_DISC,
  // Transmitted PDU
  input  wire logic                             I_TX_PDU_VALID,
  input  wire logic                             I_TX_IS_CC,
  input  wire logic                             I_TX_FROM_SINK,
  input  wire logic                             I_TX_INSERT_EN,
  // Configuration
  input  wire logic                             I_CONTINUITY_PDU_PROCESS_EN,
  input  wire logic                             I_VERIFY_PDU_PROCESS_EN,
  input  wire logic                             I_CC_CHANNEL_TYPE_SELECT,
  input  wire logic                             I_CONTINUITY_COUNTER_SELECT,
  input  wire logic                             I_VERIFY_COUNTER_SELECT,
  input  wire logic                             I_SINGLE_SESSION_MODE_EN,
  input  wire logic                             I_RX_FIELD_SAMPLING_EN,
  input  wire logic                             I_VALIDATE_CC_EN,
  input  wire logic                             I_VALIDATE_CV_EN,
  input  wire logic                             I_VERSION_CHECK_EN,
  input  wire logic                             I_MIN_LEN_CHECK_EN,
  input  wire logic                             I_DISCR_CHECK_EN,
  input  wire logic                             I_FLAG_CHECK_EN,
  input  wire logic [bfdrx_pkg::VER_W-1:0]      I_EXPECTED_PROTOCOL_VERSION,
  input  wire logic [bfdrx_pkg::LEN_W-1:0]      I_MAX_PDU_LENGTH,
  input  wire logic                             I_RX_FAIL_CPU_COPY_EN,
  input  wire logic [bfdrx_pkg::DISC_W-1:0]     I_SOURCE_LOCAL_DISCRIMINATOR,
  input  wire logic [bfdrx_pkg::DISC_W-1:0]     I_SOURCE_REMOTE_DISCRIMINATOR,
  input  wire logic [bfdrx_pkg::DISC_W-1:0]     I_SINK_LOCAL_DISCRIMINATOR,
  input  wire logic [bfdrx_pkg::DISC_W-1:0]     I_SINK_REMOTE_DISCRIMINATOR,
  input  wire logic [bfdrx_pkg::STATE_W-1:0]    I_SOURCE_OWN_STATE,
  input  wire logic [bfdrx_pkg::DIAG_W-1:0]     I_SOURCE_OWN_DIAG,
  input  wire logic [bfdrx_pkg::MULT_W-1:0]     I_SOURCE_OWN_MULTIPLIER,
  input  wire logic [bfdrx_pkg::STATE_W-1:0]    I_SINK_OWN_STATE,
  input  wire logic [bfdrx_pkg::DIAG_W-1:0]     I_SINK_OWN_DIAG,
  input  wire logic [bfdrx_pkg::MULT_W-1:0]     I_SINK_OWN_MULTIPLIER,
  input  wire logic [bfdrx_pkg::FAIL_N-1:0]     I_STICKY_CLEAR,
  input  wire logic                             I_LOSS_TICK,
  // Verdict
  output logic                                  O_PDU_ACCEPT,
  output logic                                  O_PDU_DISCARD,
  output logic                                  O_PDU_TO_SINK,
  output logic                                  O_CPU_COPY,
  output logic [bfdrx_pkg::FAIL_N-1:0]          O_STICKY,
  // Sampled peer fields
  output logic [bfdrx_pkg::STATE_W-1:0]         O_SOURCE_PEER_STATE,
  output logic [bfdrx_pkg::DIAG_W-1:0]          O_SOURCE_PEER_DIAG,
  output logic [bfdrx_pkg::MULT_W-1:0]          O_SOURCE_PEER_MULTIPLIER,
  output logic [bfdrx_pkg::STATE_W-1:0]         O_SINK_PEER_STATE,
  output logic [bfdrx_pkg::DIAG_W-1:0]          O_SINK_PEER_DIAG,
  output logic [bfdrx_pkg::MULT_W-1:0]          O_SINK_PEER_MULTIPLIER,
  // Transmit insertion
  output logic                                  O_TX_VALID,
  output logic                                  O_TX_INSERT,
  output logic [bfdrx_pkg::STATE_W-1:0]         O_TX_STATE,
  output logic [bfdrx_pkg::DIAG_W-1:0]          O_TX_DIAG,
  output logic [bfdrx_pkg::MULT_W-1:0]          O_TX_MULTIPLIER,
  // Counters and loss
  output logic [bfdrx_pkg::CNT_W-1:0]           O_RX_SEL_COUNT,
  output logic [bfdrx_pkg::CNT_W-1:0]           O_RX_NONSEL_COUNT,
  output logic [bfdrx_pkg::CNT_W-1:0]           O_TX_SEL_COUNT,
  output logic [bfdrx_pkg::CNT_W-1:0]           O_TX_NONSEL_COUNT,
  output logic [bfdrx_pkg::MULT_W-1:0]          O_LOSS_COUNT,
  output logic                                  O_CONTINUITY_LOSS
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [bfdrx_pkg::CNT_W-1:0] bump(input logic [bfdrx_pkg::CNT_W-1:0] v, input logic hit);
    bump = hit ? v + 16'h0001 : v;
  endfunction

  // ****************************************
  // PDU classification
  // ****************************************
  wire [bfdrx_pkg::CHAN_W-1:0] cc_chan = I_CC_CHANNEL_TYPE_SELECT ? bfdrx_pkg::CHAN_CC_STD
                                                                  : bfdrx_pkg::CHAN_CC_ALT; // R2
  wire is_cc  = I_PDU_VALID && I_CONTINUITY_PDU_PROCESS_EN && (I_PDU_CHANNEL == cc_chan); // R1
  wire is_cv  = I_PDU_VALID && I_VERIFY_PDU_PROCESS_EN && (I_PDU_CHANNEL == bfdrx_pkg::CHAN_CV); // R1
  wire rx_hit = is_cc || is_cv;

  // ****************************************
  // Checker
  // ****************************************
  bfdrx_chk_if chk ();

  assign chk.pdu.version          = I_PDU_VERSION;
  assign chk.pdu.length           = I_PDU_LENGTH;
  assign chk.pdu.auth             = I_PDU_AUTH;
  assign chk.pdu.multipoint       = I_PDU_MULTIPOINT;
  assign chk.pdu.mult             = I_PDU_MULT;
  assign chk.pdu.my_disc          = I_PDU_MY_DISC;
  assign chk.pdu.your_disc        = I_PDU_YOUR_DISC;
  assign chk.cfg.validate_en      = is_cc ? I_VALIDATE_CC_EN : I_VALIDATE_CV_EN; // R11
  assign chk.cfg.version_check_en = I_VERSION_CHECK_EN;
  assign chk.cfg.min_len_check_en = I_MIN_LEN_CHECK_EN;
  assign chk.cfg.discr_check_en   = I_DISCR_CHECK_EN;
  assign chk.cfg.flag_check_en    = I_FLAG_CHECK_EN;
  assign chk.cfg.single_session   = I_SINGLE_SESSION_MODE_EN; // R4 R5
  assign chk.cfg.expected_version = I_EXPECTED_PROTOCOL_VERSION;
  assign chk.cfg.max_len          = I_MAX_PDU_LENGTH;
  assign chk.cfg.src_local_disc   = I_SOURCE_LOCAL_DISCRIMINATOR;
  assign chk.cfg.src_remote_disc  = I_SOURCE_REMOTE_DISCRIMINATOR;
  assign chk.cfg.sink_local_disc  = I_SINK_LOCAL_DISCRIMINATOR;
  assign chk.cfg.sink_remote_disc = I_SINK_REMOTE_DISCRIMINATOR;

  bfdrx_checker u_checker (
    .chk (chk.decider)
  );

  wire pass     = (chk.fail == bfdrx_pkg::BFDRX_PASS);
  wire accept   = rx_hit && pass;
  wire discard  = rx_hit && !pass; // R11
  wire to_sink  = chk.to_sink && !I_SINGLE_SESSION_MODE_EN; // R4
  wire [bfdrx_pkg::FAIL_N-1:0] fail_onehot = discard ? 7'((8'h01 << chk.fail) >> 1) : bfdrx_pkg::STICKY_RST; // R12

  // ****************************************
  // Sticky and verdict
  // ****************************************
  // Set wins over a clear in the same cycle so no failure is lost
  wire [bfdrx_pkg::FAIL_N-1:0] sticky_next = (O_STICKY & ~I_STICKY_CLEAR) | fail_onehot; // R23

  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      O_STICKY      <= bfdrx_pkg::STICKY_RST;
      O_PDU_ACCEPT  <= 1'b0;
      O_PDU_DISCARD <= 1'b0;
      O_PDU_TO_SINK <= 1'b0;
      O_CPU_COPY    <= 1'b0;
    end else if (I_CLK_EN) begin
      O_STICKY      <= sticky_next; // R11 R23
      O_PDU_ACCEPT  <= accept;
      O_PDU_DISCARD <= discard; // R11
      O_PDU_TO_SINK <= rx_hit && to_sink; // R20 R22
      O_CPU_COPY    <= discard && I_RX_FAIL_CPU_COPY_EN; // R18
    end
  end

  // ****************************************
  // Peer field sampling
  // ****************************************
  wire sample      = accept && is_cc && I_RX_FIELD_SAMPLING_EN; // R9
  wire sample_src  = sample && !to_sink;
  wire sample_sink = sample && to_sink; // R5

  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      O_SOURCE_PEER_STATE      <= bfdrx_pkg::STATE_RST;
      O_SOURCE_PEER_DIAG       <= bfdrx_pkg::DIAG_RST;
      O_SOURCE_PEER_MULTIPLIER <= bfdrx_pkg::MULT_RST;
    end else if (I_CLK_EN && sample_src) begin
      O_SOURCE_PEER_STATE      <= I_PDU_STATE; // R9
      O_SOURCE_PEER_DIAG       <= I_PDU_DIAG;
      O_SOURCE_PEER_MULTIPLIER <= I_PDU_MULT;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      O_SINK_PEER_STATE      <= bfdrx_pkg::STATE_RST;
      O_SINK_PEER_DIAG       <= bfdrx_pkg::DIAG_RST;
      O_SINK_PEER_MULTIPLIER <= bfdrx_pkg::MULT_RST;
    end else if (I_CLK_EN && sample_sink) begin
      O_SINK_PEER_STATE      <= I_PDU_STATE; // R9
      O_SINK_PEER_DIAG       <= I_PDU_DIAG;
      O_SINK_PEER_MULTIPLIER <= I_PDU_MULT;
    end
  end

  // ****************************************
  // Transmit field insertion
  // ****************************************
  // Own values are only read here; nothing in this block ever writes them
  wire use_sink = I_TX_FROM_SINK && !I_SINGLE_SESSION_MODE_EN; // R4 R5
  wire [bfdrx_pkg::STATE_W-1:0] tx_state = use_sink ? I_SINK_OWN_STATE : I_SOURCE_OWN_STATE; // R6 R7
  wire [bfdrx_pkg::DIAG_W-1:0]  tx_diag  = use_sink ? I_SINK_OWN_DIAG : I_SOURCE_OWN_DIAG; // R6 R7
  wire [bfdrx_pkg::MULT_W-1:0]  tx_mult  = use_sink ? I_SINK_OWN_MULTIPLIER : I_SOURCE_OWN_MULTIPLIER; // R6 R7

  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      O_TX_VALID      <= 1'b0;
      O_TX_INSERT     <= 1'b0;
      O_TX_STATE      <= bfdrx_pkg::STATE_RST;
      O_TX_DIAG       <= bfdrx_pkg::DIAG_RST;
      O_TX_MULTIPLIER <= bfdrx_pkg::MULT_RST;
    end else if (I_CLK_EN) begin
      O_TX_VALID      <= I_TX_PDU_VALID;
      O_TX_INSERT     <= I_TX_PDU_VALID && I_TX_INSERT_EN; // R8
      O_TX_STATE      <= tx_state;
      O_TX_DIAG       <= tx_diag;
      O_TX_MULTIPLIER <= tx_mult;
    end
  end

  // ****************************************
  // Statistics
  // ****************************************
  wire rx_sel  = accept && (is_cc ? I_CONTINUITY_COUNTER_SELECT : I_VERIFY_COUNTER_SELECT); // R3
  wire tx_sel  = I_TX_IS_CC ? I_CONTINUITY_COUNTER_SELECT : I_VERIFY_COUNTER_SELECT; // R3

  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      O_RX_SEL_COUNT    <= bfdrx_pkg::CNT_RST;
      O_RX_NONSEL_COUNT <= bfdrx_pkg::CNT_RST;
      O_TX_SEL_COUNT    <= bfdrx_pkg::CNT_RST;
      O_TX_NONSEL_COUNT <= bfdrx_pkg::CNT_RST;
    end else if (I_CLK_EN) begin
      O_RX_SEL_COUNT    <= bump(O_RX_SEL_COUNT, rx_sel); // R3
      O_RX_NONSEL_COUNT <= bump(O_RX_NONSEL_COUNT, accept && !rx_sel);
      O_TX_SEL_COUNT    <= bump(O_TX_SEL_COUNT, I_TX_PDU_VALID && tx_sel);
      O_TX_NONSEL_COUNT <= bump(O_TX_NONSEL_COUNT, I_TX_PDU_VALID && !tx_sel);
    end
  end

  // ****************************************
  // Continuity loss
  // ****************************************
  // Coordinated watches the source session, independent only the sink session
  wire [bfdrx_pkg::MULT_W-1:0] loss_limit = I_SINGLE_SESSION_MODE_EN ? O_SOURCE_PEER_MULTIPLIER
                                                                     : O_SINK_PEER_MULTIPLIER; // R10
  wire loss_clear = accept && (I_SINGLE_SESSION_MODE_EN ? !to_sink : to_sink);
  // Counter saturates at the limit so one outage yields one event
  wire loss_step  = I_LOSS_TICK && !loss_clear && (O_LOSS_COUNT != loss_limit);
  wire [bfdrx_pkg::MULT_W-1:0] loss_next = loss_clear ? bfdrx_pkg::MULT_RST
                                         : loss_step  ? O_LOSS_COUNT + 8'h01 : O_LOSS_COUNT;

  always_ff @(posedge I_CLOCK) begin
    if (!I_RESETN) begin
      O_LOSS_COUNT      <= bfdrx_pkg::MULT_RST;
      O_CONTINUITY_LOSS <= 1'b0;
    end else if (I_CLK_EN) begin
      O_LOSS_COUNT      <= loss_next;
      O_CONTINUITY_LOSS <= loss_step && (loss_next == loss_limit); // R10
    end
  end

  // ****************************************
  // Checks on behaviour
  // ****************************************
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESETN);

  a_cc_gate_off: // R1
    assert property (I_CLK_EN && I_PDU_VALID && !I_CONTINUITY_PDU_PROCESS_EN &&
                     I_PDU_CHANNEL != bfdrx_pkg::CHAN_CV
                     |=> !O_PDU_ACCEPT && !O_PDU_DISCARD)
    else $error("PDU handled while processing disabled");

  a_version_reject: // R13
    assert property (I_CLK_EN && is_cc && I_VALIDATE_CC_EN && I_VERSION_CHECK_EN &&
                     I_PDU_VERSION != I_EXPECTED_PROTOCOL_VERSION
                     |=> O_PDU_DISCARD && O_STICKY[bfdrx_pkg::STK_VERSION])
    else $error("Version mismatch not rejected");

  a_one_reason: // R12
    assert property (I_CLK_EN && discard |=> $countones(O_STICKY & ~$past(O_STICKY)) <= 1)
    else $error("More than one failure reason recorded");

  a_short_len: // R14
    assert property (I_CLK_EN && rx_hit && chk.cfg.validate_en && I_MIN_LEN_CHECK_EN && !I_PDU_AUTH &&
                     (!I_VERSION_CHECK_EN || I_PDU_VERSION == I_EXPECTED_PROTOCOL_VERSION) &&
                     I_PDU_LENGTH < bfdrx_pkg::MIN_LEN_PLAIN
                     |=> O_STICKY[bfdrx_pkg::STK_SHORT_LEN] && O_PDU_DISCARD)
    else $error("Short PDU not rejected");

  a_zero_mult_acc: // R16
    assert property (I_CLK_EN && is_cc && I_VALIDATE_CC_EN && I_FLAG_CHECK_EN && I_PDU_MULT == 8'h00
                     |=> !O_PDU_ACCEPT)
    else $error("Zero multiplier accepted");

  a_sticky_hold: // R23
    assert property (I_CLK_EN && O_STICKY[bfdrx_pkg::STK_MULTIPOINT] && !I_STICKY_CLEAR[bfdrx_pkg::STK_MULTIPOINT]
                     |=> O_STICKY[bfdrx_pkg::STK_MULTIPOINT])
    else $error("Sticky bit lost without a clear");

  a_copy_needs_fail: // R18
    assert property (O_CPU_COPY |-> O_PDU_DISCARD && $past(I_RX_FAIL_CPU_COPY_EN))
    else $error("CPU copy without a failure");

  a_sample_fields: // R9
    assert property (I_CLK_EN && sample_src
                     |=> O_SOURCE_PEER_STATE == $past(I_PDU_STATE) && O_SOURCE_PEER_MULTIPLIER == $past(I_PDU_MULT))
    else $error("Peer fields not sampled");

  a_sink_sample: // R5
    assert property (I_CLK_EN && sample_sink
                     |=> O_SINK_PEER_MULTIPLIER == $past(I_PDU_MULT) && O_SINK_PEER_STATE == $past(I_PDU_STATE))
    else $error("Sink peer fields not sampled");

  a_loss_at_limit: // R10
    assert property (O_CONTINUITY_LOSS |-> O_LOSS_COUNT != 8'h00 && O_LOSS_COUNT == $past(loss_limit))
    else $error("Loss event away from the limit");

  a_coord_no_sink: // R4
    assert property (I_CLK_EN && I_SINGLE_SESSION_MODE_EN |=> !O_PDU_TO_SINK)
    else $error("Sink session used in coordinated mode");

  a_tx_own_field: // R8
    assert property (I_CLK_EN && I_TX_PDU_VALID && I_SINGLE_SESSION_MODE_EN
                     |=> O_TX_VALID && O_TX_STATE == $past(I_SOURCE_OWN_STATE))
    else $error("Own state not presented on transmit");

endmodule
